/* File: include/ssp_pkg.sv */
/*
 * Shared definitions for the synchronous serial port (SPI mode): register
 * offsets, field positions, reset values, mode codes, divider counts and
 * the carrier structs for the register port and the serial pins.
 * Assumes the system clock is the oscillator clock the divisors refer to.
 */
package ssp_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] FLAG_REG_ADDR = 8'h0C;
   localparam logic [7:0] DATA_BUF_ADDR = 8'h13;
   localparam logic [7:0] CONTROL_ADDR = 8'h14;
   localparam logic [7:0] STATUS_ADDR = 8'h94;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // Field positions
   localparam int CTL_WRITE_COLLISION_FLAG_BIT = 7;
   localparam int CTL_OV_BIT = 6;
   localparam int CTL_EN_BIT = 5;
   localparam int CTL_CKP_BIT = 4;
   localparam int STA_SMP_BIT = 7;
   localparam int STA_CKE_BIT = 6;
   localparam int STA_BF_BIT = 0;
   localparam int FLAG_PIF_BIT = 3;

   // ---------------------------------------------------------------
   // Mode codes
   // ---------------------------------------------------------------
   localparam logic [3:0] MODE_MST_DIV4 = 4'h0;
   localparam logic [3:0] MODE_MST_DIV16 = 4'h1;
   localparam logic [3:0] MODE_MST_DIV64 = 4'h2;
   localparam logic [3:0] MODE_MST_TIMER_TWO = 4'h3;
   localparam logic [3:0] MODE_SLV_SEL = 4'h4;
   localparam logic [3:0] MODE_SLV_NOSEL = 4'h5;

   // ---------------------------------------------------------------
   // Timing: half bit periods in system clocks, minus one
   // ---------------------------------------------------------------
   localparam int DIV4 = 4;
   localparam int DIV16 = 16;
   localparam int DIV64 = 64;
   localparam logic [4:0] HALF4_LIM = 5'(DIV4 / 2 - 1);
   localparam logic [4:0] HALF16_LIM = 5'(DIV16 / 2 - 1);
   localparam logic [4:0] HALF64_LIM = 5'(DIV64 / 2 - 1);
   localparam logic [4:0] LAST_EDGE = 5'h10;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_MASTER = 1'b1
   } xfer_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic sck;
      logic sdi;
      logic ss_n;
   } spi_in_t;

   typedef struct packed {
      logic sck;
      logic sck_oe;
      logic sdo;
      logic sdo_oe;
   } spi_out_t;

endpackage

/* File: rtl/sync_serial_port_spi.sv */
/*
 * Synchronous serial port, SPI mode: master at four bit rates or slave with
 * or without select control, byte shifting MSb first, receive buffer and
 * flags. Assumes a timer_two tick pulse from outside and an external pad
 * stage that resolves the enables into wire levels.
 */
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps

// Contract
// RL1: Master samples input at end of output time when phase bit set, else middle.
// RL2: Software keeps the sample phase bit clear in slave mode.
// RL3: Edge bit with polarity picks which clock edge changes output data.
// RL4: Polarity bit sets serial clock idle level, high when set.
// RL5: Port enable hands the four pins to the port; clear returns them. Code claims select only in master and select-slave modes.
// RL6: Codes 0000-0011 pick master at clock/4, /16, /64 or timer two/2.
// RL7: Code 0100 is slave with select; 0101 slave with select pin free.
// RL8: Reserved and I2C codes leave the port idle here.
// RL9: Each transfer shifts one byte out and one in, MSb first.
// RL10: Completed byte goes to buffer, then buffer-full and interrupt flags set.
// RL11: Buffer write during a transfer is dropped and sets collision flag.
// RL12: Any buffer read clears buffer-full.
// RL13: Slave byte arriving while buffer full sets overflow and is discarded.
// RL14: Software reads the buffer after every byte to avoid overflow.
// RL15: Shift register reachable only through the buffer address.
// RL16: Software should read the buffer before writing the next byte.
// RL17: Master transfer starts as soon as the buffer is written.
// RL18: Data shifts on the programmed edge and is latched on the opposite one; a master with the phase bit set latches on the shifting edge.
// RL19: Slave with select drives data-out only while select is low.
// RL20: Slave clock and select are synchronised before edge detection.
module sync_serial_port_spi
   import ssp_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Register port
   input wire bus_req_t bus_i,
   output logic [7:0] rdata_o,
   // Timer two tick
   input wire logic timer_two_tick_i,
   // Serial pins
   input wire spi_in_t spi_i,
   output spi_out_t spi_o,
   output logic [3:0] pins_claimed_o,
   // Interrupt flag level
   output logic port_interrupt_flag_o
);

   typedef struct packed {
      logic [7:0] control;
      logic input_sample_phase;
      logic cke;
      logic bf;
      logic pif;
      logic [7:0] data_buffer;
      logic [7:0] tx_shift;
      logic [7:0] rx_shift;
      logic dout;
      logic sck;
      xfer_state_t st;
      logic [4:0] edge_cnt;
      logic [4:0] div_cnt;
      logic [3:0] bit_cnt;
      logic [2:0] sck_s;
      logic [2:0] ss_s;
      logic [1:0] sdi_s;
      logic [7:0] rdata;
   } state_t;

   state_t state_r;
   state_t state_nxt;
   logic [1:0] rst_sync_r;
   logic rst_n;

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic en;
   logic clock_polarity;
   logic is_master;
   logic is_slave;
   logic sel_ctl;
   logic busy;
   logic half_tick;
   logic lead_edge;
   logic sample_now;
   logic late_skip;
   logic out_now;
   logic done;
   logic buf_wr;
   logic buf_rd;
   logic slv_edge;
   logic slv_lead;
   logic slv_sel;
   logic [3:0] mode;
   logic [4:0] half_lim;
   logic [7:0] rx_next;

   always_comb begin
      state_nxt = state_r;
      en = state_r.control[CTL_EN_BIT];
      clock_polarity = state_r.control[CTL_CKP_BIT];
      mode = state_r.control[3:0];
      is_master = en && (mode <= MODE_MST_TIMER_TWO); // [RL6]
      is_slave = en && (mode == MODE_SLV_SEL || mode == MODE_SLV_NOSEL); // [RL7] [RL8]
      sel_ctl = (mode == MODE_SLV_SEL);
      half_lim = HALF4_LIM;
      half_tick = 1'b0;
      lead_edge = 1'b0;
      sample_now = 1'b0;
      out_now = 1'b0;
      done = 1'b0;
      late_skip = 1'b0;
      rx_next = state_r.rx_shift;
      buf_wr = bus_i.wr && (bus_i.addr == DATA_BUF_ADDR); // [RL15]
      buf_rd = bus_i.rd && (bus_i.addr == DATA_BUF_ADDR);

      // Slave inputs: sdi is delayed alongside the clock to keep them aligned
      state_nxt.sck_s = {state_r.sck_s[1:0], spi_i.sck}; // [RL20]
      state_nxt.ss_s = {state_r.ss_s[1:0], spi_i.ss_n}; // [RL20]
      state_nxt.sdi_s = {state_r.sdi_s[0], spi_i.sdi};
      slv_edge = state_r.sck_s[1] != state_r.sck_s[2];
      slv_lead = slv_edge && (state_r.sck_s[1] != clock_polarity);
      slv_sel = !sel_ctl || !state_r.ss_s[1];

      busy = (state_r.st == ST_MASTER) || (is_slave && state_r.bit_cnt != 4'h0);

      // ------------------------------------------------------------
      // Register reads, data one cycle later
      // ------------------------------------------------------------
      state_nxt.rdata = 8'h00;
      if (bus_i.rd) begin
         if (bus_i.addr == DATA_BUF_ADDR) begin
            state_nxt.rdata = state_r.data_buffer;
         end else if (bus_i.addr == CONTROL_ADDR) begin
            state_nxt.rdata = state_r.control;
         end else if (bus_i.addr == STATUS_ADDR) begin
            state_nxt.rdata = {state_r.input_sample_phase, state_r.cke, 5'h00, state_r.bf};
         end else if (bus_i.addr == FLAG_REG_ADDR) begin
            state_nxt.rdata = {4'h0, state_r.pif, 3'h0};
         end
      end
      if (buf_rd) begin
         state_nxt.bf = 1'b0; // [RL12]
      end

      // ------------------------------------------------------------
      // Register writes; hardware sets below take priority
      // ------------------------------------------------------------
      if (bus_i.wr) begin
         if (bus_i.addr == CONTROL_ADDR) begin
            state_nxt.control = bus_i.wdata;
         end else if (bus_i.addr == STATUS_ADDR) begin
            state_nxt.input_sample_phase = bus_i.wdata[STA_SMP_BIT];
            state_nxt.cke = bus_i.wdata[STA_CKE_BIT];
         end else if (bus_i.addr == FLAG_REG_ADDR) begin
            state_nxt.pif = bus_i.wdata[FLAG_PIF_BIT];
         end
      end
      if (buf_wr) begin
         if (busy) begin
            state_nxt.control[CTL_WRITE_COLLISION_FLAG_BIT] = 1'b1; // [RL11]
         end else begin
            // Edge bit clear: first bit must stand before the first edge
            state_nxt.tx_shift = state_r.cke ? bus_i.wdata : {bus_i.wdata[6:0], 1'b0};
            state_nxt.dout = state_r.cke ? state_r.dout : bus_i.wdata[7];
            state_nxt.bit_cnt = 4'h0;
            if (is_master) begin
               state_nxt.st = ST_MASTER; // [RL17]
               state_nxt.edge_cnt = 5'h00;
               state_nxt.div_cnt = 5'h00;
               state_nxt.rx_shift = 8'h00;
            end
         end
      end

      // ------------------------------------------------------------
      // Master engine
      // ------------------------------------------------------------
      if (mode == MODE_MST_DIV16) begin
         half_lim = HALF16_LIM;
      end else if (mode == MODE_MST_DIV64) begin
         half_lim = HALF64_LIM;
      end
      if (state_r.st == ST_MASTER) begin
         if (mode == MODE_MST_TIMER_TWO) begin
            half_tick = timer_two_tick_i; // [RL6]
         end else if (state_r.div_cnt == half_lim) begin
            half_tick = 1'b1;
            state_nxt.div_cnt = 5'h00;
         end else begin
            state_nxt.div_cnt = state_r.div_cnt + 5'h01;
         end
         if (half_tick) begin
            // Even edges lead, odd edges trail; output on leading when edge bit set
            lead_edge = !state_r.edge_cnt[0];
            // Edge bit set: the first leading edge already carries the top bit
            out_now = (lead_edge == state_r.cke) && (state_r.edge_cnt < 5'h0F); // [RL3] [RL18]
            // Sample mid-bit, or one half period later at the end of the bit.
            // Edge bit set: no bit stands before edge 0, so the late sample
            // starts on edge 2 and the eighth one lands on the closing edge
            late_skip = state_r.cke && state_r.input_sample_phase && (state_r.edge_cnt == 5'h00);
            sample_now = (state_r.edge_cnt[0] == (state_r.cke ^ state_r.input_sample_phase))
                         && (state_r.bit_cnt < BITS_PER_BYTE) && !late_skip; // [RL1] [RL18]
            if (state_r.edge_cnt < LAST_EDGE) begin
               state_nxt.sck = !state_r.sck;
            end
            if (state_r.edge_cnt == LAST_EDGE) begin
               done = 1'b1;
               state_nxt.st = ST_IDLE;
               state_nxt.sck = clock_polarity;
            end else begin
               state_nxt.edge_cnt = state_r.edge_cnt + 5'h01;
            end
         end
      end else begin
         state_nxt.sck = clock_polarity; // [RL4]
      end

      // ------------------------------------------------------------
      // Slave engine
      // ------------------------------------------------------------
      if (is_slave) begin
         if (!slv_sel) begin
            // Select high aborts the byte in progress
            state_nxt.bit_cnt = 4'h0; // [RL19]
         end else if (slv_edge) begin
            out_now = (slv_lead == state_r.cke) && (state_r.bit_cnt != 4'h0 || state_r.cke); // [RL3] [RL18]
            sample_now = (slv_lead != state_r.cke); // [RL18]
         end
      end

      // ------------------------------------------------------------
      // Shifting and completion
      // ------------------------------------------------------------
      if (out_now) begin
         state_nxt.dout = state_r.tx_shift[7]; // [RL9]
         state_nxt.tx_shift = {state_r.tx_shift[6:0], 1'b0};
      end
      if (sample_now) begin
         rx_next = {state_r.rx_shift[6:0], is_slave ? state_r.sdi_s[1] : spi_i.sdi}; // [RL9]
         state_nxt.rx_shift = rx_next;
         state_nxt.bit_cnt = state_r.bit_cnt + 4'h1;
         if (is_slave && state_r.bit_cnt == BITS_PER_BYTE - 4'h1) begin
            done = 1'b1;
            state_nxt.bit_cnt = 4'h0;
         end
      end
      if (done) begin
         if (is_slave && state_r.bf && !buf_rd) begin
            state_nxt.control[CTL_OV_BIT] = 1'b1; // [RL13]
         end else begin
            state_nxt.data_buffer = rx_next; // [RL10]
            state_nxt.bf = 1'b1; // [RL10]
            state_nxt.pif = 1'b1; // [RL10]
         end
         state_nxt.bit_cnt = 4'h0;
      end

      // Disable or a non-SPI code parks the engine
      if (!is_master && !is_slave) begin
         state_nxt.st = ST_IDLE;
         state_nxt.bit_cnt = 4'h0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= '0;
         state_r.control <= CONTROL_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rdata_o = state_r.rdata;
   assign port_interrupt_flag_o = state_r.pif;
   assign spi_o.sck = state_r.sck;
   assign spi_o.sck_oe = is_master; // [RL5]
   assign spi_o.sdo = state_r.dout;
   // Release follows the select pin after the two-flop synchroniser delay
   assign spi_o.sdo_oe = is_master || (is_slave && (!sel_ctl || !state_r.ss_s[1])); // [RL19]
   // Order: sck, sdo, sdi, select
   assign pins_claimed_o = {en, en, en, en && (is_master || sel_ctl)}; // [RL5]

endmodule // sync_serial_port_spi

/* File: dv/ssp_checker_asserts.sv */
/* Checker for the serial port top-level ports.
   Assumes the bind at the foot attaches it to sync_serial_port_spi. */
`timescale 1ns/1ps
module ssp_checker
   import ssp_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Watched ports
   input wire bus_req_t bus_i,
   input wire logic [7:0] rdata_o,
   input wire spi_in_t spi_i,
   input wire spi_out_t spi_o,
   input wire logic [3:0] pins_claimed_o
);
   // Shadow of software settings only; hardware-set flags are not needed
   logic [7:0] ctl_q;
   logic cke_q;
   logic [9:0] buf_age;
   logic [9:0] ctl_age;
   logic is_mst;
   logic sel_slv;
   logic mapped;
   assign is_mst = ctl_q[CTL_EN_BIT] && (ctl_q[3:0] < MODE_SLV_SEL);
   assign sel_slv = ctl_q[CTL_EN_BIT] && (ctl_q[3:0] == MODE_SLV_SEL);
   assign mapped = bus_i.addr inside {FLAG_REG_ADDR, DATA_BUF_ADDR, CONTROL_ADDR, STATUS_ADDR};
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctl_q <= 8'h00;
         cke_q <= 1'b0;
         buf_age <= 10'h3FF;
         ctl_age <= 10'h3FF;
      end else begin
         if (bus_i.wr && bus_i.addr == CONTROL_ADDR) ctl_q <= bus_i.wdata;
         if (bus_i.wr && bus_i.addr == STATUS_ADDR) cke_q <= bus_i.wdata[STA_CKE_BIT];
         buf_age <= (bus_i.wr && bus_i.addr == DATA_BUF_ADDR) ? 10'h000
            : buf_age + 10'(buf_age != 10'h3FF);
         ctl_age <= (bus_i.wr && bus_i.addr inside {CONTROL_ADDR, STATUS_ADDR}) ? 10'h000
            : ctl_age + 10'(ctl_age != 10'h3FF);
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   property p_idle; (is_mst && buf_age > 10'h2BC && ctl_age > 10'h002)
      |-> spi_o.sck == ctl_q[CTL_CKP_BIT]; endproperty
   a_idle: assert property (p_idle) else $error("sck off its idle level");
   property p_off; !ctl_q[CTL_EN_BIT] |-> pins_claimed_o == 4'h0 && !spi_o.sck_oe; endproperty
   a_off: assert property (p_off) else $error("pins held while disabled");
   property p_nosel; (ctl_q[CTL_EN_BIT] && ctl_q[3:0] == MODE_SLV_NOSEL)
      |-> pins_claimed_o == 4'hE && !spi_o.sck_oe; endproperty
   a_nosel: assert property (p_nosel) else $error("select pin claimed");
   property p_start; (bus_i.wr && bus_i.addr == DATA_BUF_ADDR && is_mst && buf_age > 10'h2BC)
      |-> ##[1:40] spi_o.sck != ctl_q[CTL_CKP_BIT]; endproperty
   a_start: assert property (p_start) else $error("master transfer did not start");
   property p_rel; (sel_slv && spi_i.ss_n) [*3] |-> !spi_o.sdo_oe; endproperty
   a_rel: assert property (p_rel) else $error("data out driven while deselected");
   property p_unmap; (bus_i.rd && !mapped) |=> rdata_o == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_bf; (bus_i.rd && bus_i.addr == DATA_BUF_ADDR) ##2
      (bus_i.rd && bus_i.addr == STATUS_ADDR) |=> !rdata_o[STA_BF_BIT]; endproperty
   a_bf: assert property (p_bf) else $error("buffer flag kept after read");
   // Data out may move only on the programmed clock edge
   property p_edge; (is_mst && ctl_age > 10'h002 && buf_age > 10'h002 && buf_age < 10'h2BC
      && $changed(spi_o.sdo)) |-> $changed(spi_o.sck)
      && spi_o.sck == (ctl_q[CTL_CKP_BIT] ^ cke_q); endproperty
   a_edge: assert property (p_edge) else $error("data out moved on wrong edge");
endmodule // ssp_checker

bind sync_serial_port_spi ssp_checker checker_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
   .bus_i(bus_i), .rdata_o(rdata_o), .spi_i(spi_i), .spi_o(spi_o),
   .pins_claimed_o(pins_claimed_o));

/* File: dv/spi_far_end.sv */
/* Far-end SPI slave model for master-mode traffic.
   Assumes the bench pulses load_i before each byte and holds the modes steady. */
`timescale 1ns/1ps
module spi_far_end (
   // Serial lines and settings
   input wire logic sck_i,
   input wire logic sdo_i,
   input wire logic cpol_i,
   input wire logic cke_i,
   input wire logic load_i,
   input wire logic [7:0] tx_i,
   // Outputs
   output logic sdi_o,
   output logic [7:0] rx_o
);
   logic [7:0] txb = 8'h00;
   int idx = 7;
   int edges = 16;
   logic armed = 1'b0;
   // One process owns both outputs; a load is taken once per rising strobe
   // No select line, so the last bit is held rather than released
   always @(posedge load_i or sck_i) begin
      if (load_i && !armed) begin
         armed = 1'b1;
         txb = tx_i;
         idx = 7;
         edges = 0;
         sdi_o = tx_i[7];
      end else if (edges < 16) begin
         edges++;
         if ((sck_i != cpol_i) != cke_i) rx_o = {rx_o[6:0], sdo_i};
         else if (edges > 1 && idx > 0) begin
            idx--;
            sdi_o = txb[idx];
         end
      end
      if (!load_i) armed = 1'b0;
   end
endmodule // spi_far_end

/* File: dv/testbench.sv */
/* Bench for the serial port: register tasks, far-end model, byte scenarios.
   Assumes the package, the checker and the far-end model compile first. */
`timescale 1ns/1ps
module testbench
   import ssp_pkg::*;
;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   bus_req_t bus_i = '0;
   logic timer_two_tick_i = 1'b0;
   logic sck = 1'b0;
   logic tb_sdi = 1'b0;
   logic ss_n = 1'b1;
   logic slave = 1'b0;
   logic p_sdi;
   logic p_cpol = 1'b0;
   logic p_cke = 1'b0;
   logic p_load = 1'b0;
   logic [7:0] p_tx = 8'h00;
   logic [7:0] p_rx;
   logic [7:0] g;
   spi_in_t spi_i;
   spi_out_t spi_o;
   logic [7:0] rdata_o;
   logic [3:0] pins_claimed_o;
   logic flag;
   int err_total = 0;
   int checks = 0;
   assign spi_i = {sck, slave ? tb_sdi : p_sdi, ss_n};
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) timer_two_tick_i <= ~timer_two_tick_i;
   sync_serial_port_spi uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus_i),
      .rdata_o(rdata_o), .timer_two_tick_i(timer_two_tick_i), .spi_i(spi_i),
      .spi_o(spi_o), .pins_claimed_o(pins_claimed_o), .port_interrupt_flag_o(flag));
   spi_far_end far (.sck_i(spi_o.sck), .sdo_i(spi_o.sdo), .cpol_i(p_cpol), .cke_i(p_cke),
      .load_i(p_load), .tx_i(p_tx), .sdi_o(p_sdi), .rx_o(p_rx));
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // A spare cycle after each strobe keeps a strobe from being set twice at one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus_i <= '{1'b1, 1'b0, a, d};
      @(posedge clk_i);
      bus_i <= '0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      bus_i <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_i);
      bus_i <= '0;
      #1 d = rdata_o;
      @(posedge clk_i);
   endtask
   task automatic wait_flag;
      int n;
      n = 0;
      while (flag !== 1'b1 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      if (n == 3000) begin
         err_total++;
         close_out();
      end
   endtask
   task automatic master_xfer(input logic [3:0] m, input logic clock_polarity, input logic cke,
         input logic input_sample_phase, input logic [7:0] dv, input logic [7:0] pv);
      wr(STATUS_ADDR, {input_sample_phase, cke, 6'h00});
      wr(CONTROL_ADDR, {3'h1, clock_polarity, m});
      // Far-end settings settle well before the load strobe takes them
      p_cpol <= clock_polarity;
      p_cke <= cke;
      p_tx <= pv;
      repeat (4) @(posedge clk_i);
      chk("sck idle", {7'h00, spi_o.sck}, {7'h00, clock_polarity});
      chk("pins master", {4'h0, pins_claimed_o}, 8'h0F);
      chk("sck driven", {7'h00, spi_o.sck_oe}, 8'h01);
      p_load <= 1'b1;
      wr(DATA_BUF_ADDR, dv);
      p_load <= 1'b0;
      wr(DATA_BUF_ADDR, ~dv);
      wait_flag();
      rd(CONTROL_ADDR, g);
      chk("collision", g & 8'h80, 8'h80);
      rd(DATA_BUF_ADDR, g);
      chk("rx byte", g, pv);
      rd(STATUS_ADDR, g);
      chk("bf after read", g & 8'h01, 8'h00);
      chk("far end byte", p_rx, dv);
      wr(FLAG_REG_ADDR, 8'h00);
   endtask
   task automatic slave_byte(input logic [7:0] b, output logic [7:0] seen);
      for (int i = 7; i >= 0; i--) begin
         tb_sdi <= b[i];
         repeat (8) @(posedge clk_i);
         seen[i] = spi_o.sdo;
         sck <= 1'b1;
         repeat (8) @(posedge clk_i);
         sck <= 1'b0;
      end
      repeat (8) @(posedge clk_i);
      tb_sdi <= ~b[0];
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(CONTROL_ADDR, g);
      chk("control reset", g, CONTROL_RESET);
      rd(STATUS_ADDR, g);
      chk("status reset", g, STATUS_RESET);
      rd(8'h20, g);
      chk("unmapped", g, 8'h00);
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         master_xfer(4'(i), i[0], i[1], i[0] ^ i[1], 8'hA5 + 8'(i), 8'h3C ^ 8'(i << 4));
         $display("master mode %0d done", i);
      end
      slave <= 1'b1;
      wr(STATUS_ADDR, 8'h00);
      wr(CONTROL_ADDR, 8'h25);
      chk("pins no select", {4'h0, pins_claimed_o}, 8'h0E);
      wr(DATA_BUF_ADDR, 8'h96);
      slave_byte(8'h5A, g);
      chk("slave out", g, 8'h96);
      wait_flag();
      wr(FLAG_REG_ADDR, 8'h00);
      slave_byte(8'hC3, g);
      repeat (8) @(posedge clk_i);
      chk("no flag on overflow", {7'h00, flag}, 8'h00);
      rd(CONTROL_ADDR, g);
      chk("overflow", g & 8'h40, 8'h40);
      rd(DATA_BUF_ADDR, g);
      chk("kept byte", g, 8'h5A);
      wr(CONTROL_ADDR, 8'h24);
      repeat (4) @(posedge clk_i);
      chk("sdo released", {7'h00, spi_o.sdo_oe}, 8'h00);
      ss_n <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("sdo driven", {7'h00, spi_o.sdo_oe}, 8'h01);
      chk("pins select", {4'h0, pins_claimed_o}, 8'h0F);
      ss_n <= 1'b1;
      $display("slave test done");
      slave <= 1'b0;
      wr(CONTROL_ADDR, 8'h28);
      wr(DATA_BUF_ADDR, 8'h11);
      repeat (200) @(posedge clk_i);
      chk("reserved idle", {7'h00, flag}, 8'h00);
      wr(CONTROL_ADDR, 8'h00);
      chk("pins off", {4'h0, pins_claimed_o}, 8'h00);
      $display("reserved and disable test done");
      close_out();
   end
endmodule // testbench
